//--- fsb_pkg.sv
// Package for the status and block protection logic of the serial flash.
// Assumes both the core clock domain and the serial link domain import it.
package fsb_pkg;

  // Status byte field positions
  localparam int FSB_BIT_LOCK   = 7;
  localparam int FSB_BIT_LVL3   = 6;
  localparam int FSB_BIT_TB     = 5;
  localparam int FSB_BIT_LVL_HI = 4;
  localparam int FSB_BIT_LVL_LO = 2;
  localparam int FSB_BIT_WEL    = 1;
  localparam int FSB_BIT_BUSY   = 0;
  // Flag status ready bit position
  localparam int FSB_FLAG_READY = 7;

  // Array geometry
  localparam int FSB_ADDR_W   = 28;
  localparam int FSB_SECT_W   = 12;
  localparam int FSB_SECT_LSB = 16;

  // Reset values
  localparam logic [5:0] FSB_NV_RESET   = 6'h00;
  localparam logic       FSB_WEL_RESET  = 1'b0;
  localparam logic [7:0] FSB_BYTE_RESET = 8'h00;

  // Protection level limits
  localparam logic [3:0] FSB_LVL_TOP_MIN = 4'h4;
  localparam logic [3:0] FSB_LVL_ALL_MIN = 4'hd;

  // Internal cycle length of a write, program or erase, in core cycles
  localparam int FSB_BUSY_CYCLES = 16;

  // Commands seen at the link
  typedef enum logic [3:0] {
    FSB_OP_RD_STATUS,
    FSB_OP_RD_FLAG,
    FSB_OP_WR_ENABLE,
    FSB_OP_WR_DISABLE,
    FSB_OP_WR_STATUS,
    FSB_OP_PROGRAM,
    FSB_OP_ERASE_4K,
    FSB_OP_ERASE_32K,
    FSB_OP_ERASE_SECTOR,
    FSB_OP_ERASE_DIE
  } fsb_op_t;

  // One decoded command
  typedef struct packed {
    fsb_op_t                 op;
    logic [FSB_ADDR_W-1:0]   addr;
    logic [7:0]              data;
  } fsb_cmd_t;

endpackage

//--- fsb_protect.sv
// Status byte, write-enable latch, busy flag and sector protection gate.
// Assumes a decoded command port on the serial clock; core state on ref_clk_i.
// How it works
// - Status read returns status byte; status write updates its writable bits.
// - Lock bit set with write-protect low freezes nonvolatile bits, ignores writes.
// - Only raising write-protect or reset leaves hardware lock; no command releases it.
// - Lock bit resets to zero; alone it never blocks status writes.
// - Top/bottom bit selects protection from top (0) or bottom (1).
// - Nonzero protection level rejects program and erase on protected sectors.
// - Top codes 4-12, bottom codes 1-12 scale by powers; 13-15 all; 0 none.
// - Write-enable latch clears at reset and must be set before any write.
// - Status bit 0 reads one while an internal cycle runs.
// - Status bit 0 always equals inverse of flag ready bit.
// - Die erase runs only when all protection level bits are zero.
// - Sector index is address bits 27:16 of a 28-bit space.
// - Flag ready bit reads zero while busy, one when ready.
module fsb_protect
  import fsb_pkg::*;
#(
  parameter int unsigned BUSY_CYCLES = FSB_BUSY_CYCLES
) (
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             link_clk_i,
  input  wire logic             wp_n_i,
  input  wire logic             cmd_valid_i,
  input  wire fsb_pkg::fsb_cmd_t cmd_i,
  output logic                  cmd_ready_o,
  output logic                  rsp_valid_o,
  output logic [7:0]            rsp_data_o,
  output logic                  busy_o,
  output logic                  flag_ready_o,
  output logic                  op_accept_o,
  output logic                  op_reject_o
);
  import fsb_pkg::*;

  // Core state
  logic [5:0]  nv_r;
  logic        wel_r;
  logic        busy_r;
  logic [15:0] busy_cnt_r;
  logic        wp_s1_r;
  logic        wp_s2_r;
  logic        req_s1_r;
  logic        req_s2_r;
  logic        req_seen_r;
  logic [7:0]  pub_r;
  logic        pub_tgl_r;
  logic        pack_s1_r;
  logic        pack_s2_r;
  logic        accept_r;
  logic        reject_r;
  // Link state
  logic        lrst_s1_r;
  logic        lrst_r;
  logic        req_tgl_r;
  fsb_cmd_t    hold_r;
  logic        ack_s1_r;
  logic        ack_s2_r;
  logic        pub_s1_r;
  logic        pub_s2_r;
  logic        pub_seen_r;
  logic [7:0]  mirror_r;
  logic        rsp_valid_r;
  logic [7:0]  rsp_data_r;

  logic              lock_bit;
  logic              tb_bit;
  logic [3:0]        protect_level_bits;
  logic              hw_locked;
  logic [7:0]        status;
  logic [FSB_SECT_W-1:0] sector;
  logic [FSB_SECT_W:0]   span;
  logic              prot_hit;
  logic              cmd_new;
  logic              is_wr;
  logic              is_mem;
  logic              is_die;
  logic              op_go;
  logic              op_rej;
  logic              link_read;

  // Field view of the nonvolatile bits
  assign lock_bit           = nv_r[5];
  assign tb_bit             = nv_r[4];
  assign protect_level_bits = nv_r[3:0];
  assign hw_locked          = lock_bit & ~wp_s2_r;

  // Status byte assembly
  always_comb begin
    status                               = FSB_BYTE_RESET;
    status[FSB_BIT_LOCK]                 = lock_bit;
    status[FSB_BIT_LVL3]                 = protect_level_bits[3];
    status[FSB_BIT_TB]                   = tb_bit;
    status[FSB_BIT_LVL_HI:FSB_BIT_LVL_LO] = protect_level_bits[2:0];
    status[FSB_BIT_WEL]                  = wel_r;
    status[FSB_BIT_BUSY]                 = busy_r;
  end

  // Sector decode and protected range
  assign sector = hold_r.addr[FSB_SECT_LSB +: FSB_SECT_W];
  assign span   = (protect_level_bits == 4'h0) ? 13'h0000 :
                  13'(13'h0001 << (protect_level_bits - 4'h1));
  always_comb begin
    if (protect_level_bits >= FSB_LVL_ALL_MIN) begin
      prot_hit = 1'b1;
    end else if (tb_bit) begin
      prot_hit = ({1'b0, sector} < span);
    end else if (protect_level_bits < FSB_LVL_TOP_MIN) begin
      prot_hit = 1'b0;
    end else begin
      prot_hit = (13'({1'b0, sector} + span) > 13'h0fff);
    end
  end

  // Command decode in the core domain
  assign cmd_new = req_s2_r != req_seen_r;
  assign is_wr   = hold_r.op == FSB_OP_WR_STATUS;
  assign is_die  = hold_r.op == FSB_OP_ERASE_DIE;
  assign is_mem  = (hold_r.op == FSB_OP_PROGRAM) || (hold_r.op == FSB_OP_ERASE_4K) ||
                   (hold_r.op == FSB_OP_ERASE_32K) || (hold_r.op == FSB_OP_ERASE_SECTOR) ||
                   is_die;
  // Acceptance gate
  always_comb begin
    op_go = 1'b0;
    if (cmd_new && wel_r && !busy_r) begin
      if (is_wr) begin
        op_go = !hw_locked;
      end else if (is_die) begin
        op_go = (protect_level_bits == 4'h0);
      end else if (is_mem) begin
        op_go = !prot_hit;
      end
    end
  end
  assign op_rej = cmd_new && (is_wr || is_mem) && !op_go;

  // Pin synchroniser for write protect
  always_ff @(posedge ref_clk_i) begin
    wp_s1_r <= wp_n_i;
    wp_s2_r <= wp_s1_r;
  end

  // Command handshake receive
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      req_s1_r   <= 1'b0;
      req_s2_r   <= 1'b0;
      req_seen_r <= 1'b0;
    end else begin
      req_s1_r   <= req_tgl_r;
      req_s2_r   <= req_s1_r;
      req_seen_r <= req_s2_r;
    end
  end

  // Nonvolatile bits
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      nv_r <= FSB_NV_RESET;
    end else if (op_go && is_wr) begin
      nv_r <= {hold_r.data[FSB_BIT_LOCK], hold_r.data[FSB_BIT_TB], hold_r.data[FSB_BIT_LVL3],
               hold_r.data[FSB_BIT_LVL_HI:FSB_BIT_LVL_LO]};
    end
  end

  // Write-enable latch
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wel_r <= FSB_WEL_RESET;
    end else if (op_go || op_rej) begin
      wel_r <= 1'b0;
    end else if (cmd_new && !busy_r && hold_r.op == FSB_OP_WR_ENABLE) begin
      wel_r <= 1'b1;
    end else if (cmd_new && hold_r.op == FSB_OP_WR_DISABLE) begin
      wel_r <= 1'b0;
    end
  end

  // Internal cycle timer
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      busy_r     <= 1'b0;
      busy_cnt_r <= 16'h0000;
    end else if (op_go) begin
      busy_r     <= 1'b1;
      busy_cnt_r <= 16'(BUSY_CYCLES - 1);
    end else if (busy_r && busy_cnt_r == 16'h0000) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      busy_cnt_r <= busy_cnt_r - 16'h0001;
    end
  end

  // Outcome pulses
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      accept_r <= 1'b0;
      reject_r <= 1'b0;
    end else begin
      accept_r <= op_go;
      reject_r <= op_rej;
    end
  end

  // Status publish toward the link, one word per handshake
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pub_r     <= FSB_BYTE_RESET;
      pub_tgl_r <= 1'b0;
      pack_s1_r <= 1'b0;
      pack_s2_r <= 1'b0;
    end else begin
      pack_s1_r <= pub_seen_r;
      pack_s2_r <= pack_s1_r;
      if (pub_tgl_r == pack_s2_r && pub_r != status) begin
        pub_r     <= status;
        pub_tgl_r <= ~pub_tgl_r;
      end
    end
  end

  assign busy_o       = busy_r;
  assign flag_ready_o = ~busy_r;
  assign op_accept_o  = accept_r;
  assign op_reject_o  = reject_r;

  // Link domain reset
  always_ff @(posedge link_clk_i) begin
    lrst_s1_r <= reset_i;
    lrst_r    <= lrst_s1_r;
  end

  assign link_read   = (cmd_i.op == FSB_OP_RD_STATUS) || (cmd_i.op == FSB_OP_RD_FLAG);
  assign cmd_ready_o = !lrst_r && (link_read || (req_tgl_r == ack_s2_r));

  // Link side command launch and read answers
  always_ff @(posedge link_clk_i) begin
    if (lrst_r) begin
      req_tgl_r   <= 1'b0;
      hold_r      <= '0;
      ack_s1_r    <= 1'b0;
      ack_s2_r    <= 1'b0;
      pub_s1_r    <= 1'b0;
      pub_s2_r    <= 1'b0;
      pub_seen_r  <= 1'b0;
      mirror_r    <= FSB_BYTE_RESET;
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= FSB_BYTE_RESET;
    end else begin
      ack_s1_r    <= req_seen_r;
      ack_s2_r    <= ack_s1_r;
      pub_s1_r    <= pub_tgl_r;
      pub_s2_r    <= pub_s1_r;
      rsp_valid_r <= cmd_valid_i && link_read;
      if (pub_s2_r != pub_seen_r) begin
        mirror_r   <= pub_r;
        pub_seen_r <= pub_s2_r;
      end
      if (cmd_valid_i && cmd_ready_o && !link_read) begin
        hold_r    <= cmd_i;
        req_tgl_r <= ~req_tgl_r;
      end
      if (cmd_valid_i && cmd_i.op == FSB_OP_RD_STATUS) begin
        rsp_data_r <= mirror_r;
      end else if (cmd_valid_i && cmd_i.op == FSB_OP_RD_FLAG) begin
        rsp_data_r <= {~mirror_r[FSB_BIT_BUSY], 7'h00};
      end
    end
  end

  assign rsp_valid_o = rsp_valid_r;
  assign rsp_data_o  = rsp_data_r;

  // Checks
  property p_go_busy;
    @(posedge ref_clk_i) disable iff (reset_i) op_go |=> busy_r [*4];
  endproperty
  a_go_busy: assert property (p_go_busy) else $error("busy not held after accept");
  property p_need_wel;
    @(posedge ref_clk_i) disable iff (reset_i) op_go |-> wel_r && !busy_r;
  endproperty
  a_need_wel: assert property (p_need_wel) else $error("accept without latch");
  property p_wel_drop;
    @(posedge ref_clk_i) disable iff (reset_i) (op_go || op_rej) |=> !wel_r && (accept_r || reject_r);
  endproperty
  a_wel_drop: assert property (p_wel_drop) else $error("latch kept after op");
  property p_locked;
    @(posedge ref_clk_i) disable iff (reset_i) (cmd_new && is_wr && hw_locked) |=> $stable(nv_r);
  endproperty
  a_locked: assert property (p_locked) else $error("locked status changed");
  property p_wr_ok;
    @(posedge ref_clk_i) disable iff (reset_i)
      (cmd_new && is_wr && wel_r && !busy_r && !hw_locked) |=> nv_r[5] == $past(hold_r.data[7]);
  endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("status write lost");
  property p_die;
    @(posedge ref_clk_i) disable iff (reset_i) (op_go && is_die) |-> protect_level_bits == 4'h0;
  endproperty
  a_die: assert property (p_die) else $error("die erase while protected");
  property p_prot;
    @(posedge ref_clk_i) disable iff (reset_i) (op_go && is_mem && !is_die) |-> !prot_hit;
  endproperty
  a_prot: assert property (p_prot) else $error("protected sector accepted");
  property p_top_low;
    @(posedge ref_clk_i) disable iff (reset_i)
      (!tb_bit && protect_level_bits < FSB_LVL_TOP_MIN) |-> !prot_hit;
  endproperty
  a_top_low: assert property (p_top_low) else $error("low top code protects");
  property p_all;
    @(posedge ref_clk_i) disable iff (reset_i) (protect_level_bits >= FSB_LVL_ALL_MIN) |-> prot_hit;
  endproperty
  a_all: assert property (p_all) else $error("high code leaves sector open");
  property p_wren;
    @(posedge ref_clk_i) disable iff (reset_i)
      (cmd_new && !busy_r && hold_r.op == FSB_OP_WR_ENABLE) |=> wel_r [*2];
  endproperty
  a_wren: assert property (p_wren) else $error("write enable not latched");
  property p_flag;
    @(posedge ref_clk_i) disable iff (reset_i) $fell(busy_r) |-> flag_ready_o && !status[0];
  endproperty
  a_flag: assert property (p_flag) else $error("flag and busy disagree");

endmodule

//--- fsb_host.sv
// Host model: issues one command at a time on the link command port.
// Assumes link_clk_i runs freely and the block's reset has been released.
module fsb_host
  import fsb_pkg::*;
(
  input  wire logic        link_clk_i,
  input  wire logic        cmd_ready_i,
  input  wire logic        rsp_valid_i,
  input  wire logic [7:0]  rsp_data_i,
  output logic             cmd_valid_o,
  output fsb_pkg::fsb_cmd_t cmd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rsp_r;
  logic       rsp_ok_r;

  // Idle bus at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
    rsp_r = 8'h00;
    rsp_ok_r = 1'b0;
  end

  // Present, hold until taken, then scramble the released bus
  task automatic send(input fsb_op_t op, input logic [27:0] addr, input logic [7:0] data);
    int n;
    n = 0;
    @(posedge link_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o <= '{op: op, addr: addr, data: data};
    do begin
      @(posedge link_clk_i);
      n++;
    end while (cmd_ready_i !== 1'b1 && n < 100);
    cmd_valid_o <= 1'b0;
    cmd_o <= fsb_cmd_t'(~cmd_o);
    rsp_ok_r = 1'b0;
    // Answer to a read lands within a link cycle of the take
    for (int i = 0; i < 3 && !rsp_ok_r; i++) begin
      #1;
      if (rsp_valid_i === 1'b1) begin
        rsp_ok_r = 1'b1;
        rsp_r = rsp_data_i;
      end
      if (!rsp_ok_r) @(posedge link_clk_i);
    end
  endtask
endmodule

//--- flash_status_block_protection_test.sv
// Testbench for the status byte and sector protection block.
// Assumes fsb_host drives the link port; both clocks made here.
module flash_status_block_protection_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fsb_pkg::*;

  typedef struct packed {
    logic        tb;
    logic [3:0]  code;
    logic [11:0] sec;
    logic        acc;
  } fsb_case_t;

  logic       ref_clk_i, link_clk_i, reset_i, wp_n_i, cmd_valid_i;
  fsb_cmd_t   cmd_i;
  logic       cmd_ready_o, rsp_valid_o, busy_o, flag_ready_o, op_accept_o, op_reject_o;
  logic [7:0] rsp_data_o;
  int         failures, checked, acc_cnt, rej_cnt, bw;

  fsb_protect #(.BUSY_CYCLES(FSB_BUSY_CYCLES)) DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .link_clk_i(link_clk_i), .wp_n_i(wp_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .busy_o(busy_o), .flag_ready_o(flag_ready_o), .op_accept_o(op_accept_o),
    .op_reject_o(op_reject_o));
  fsb_host host (.link_clk_i(link_clk_i), .cmd_ready_i(cmd_ready_o), .rsp_valid_i(rsp_valid_o),
    .rsp_data_i(rsp_data_o), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));

  // Core and unrelated link clocks
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #40 link_clk_i = ~link_clk_i;
  end

  // Count outcome pulses and busy width between core edges
  always @(negedge ref_clk_i) begin
    if (op_accept_o === 1'b1) acc_cnt++;
    if (op_reject_o === 1'b1) rej_cnt++;
    if (busy_o === 1'b1) begin
      bw++;
    end else if (bw != 0) begin
      chk_byte(8'(bw), 8'(FSB_BUSY_CYCLES), "busy length");
      bw = 0;
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] sb(input logic [3:0] c, input logic t, input logic l);
    return {l, c[3], t, c[2:0], 2'b00};
  endfunction

  task automatic settle();
    repeat (6) @(posedge link_clk_i);
  endtask

  task automatic rd(output logic [7:0] b);
    host.send(FSB_OP_RD_STATUS, '0, '0);
    chk_bit(host.rsp_ok_r, 1'b1, "read answered");
    b = host.rsp_r;
  endtask

  // One gated operation with optional write enable first
  task automatic do_op(input fsb_op_t op, input logic [27:0] a, input logic [7:0] d,
                       input logic wel, input logic exp_acc);
    int a0, r0, n;
    logic [7:0] b;
    if (wel) host.send(FSB_OP_WR_ENABLE, '0, '0);
    settle();
    a0 = acc_cnt;
    r0 = rej_cnt;
    n = 0;
    host.send(op, a, d);
    while (acc_cnt == a0 && rej_cnt == r0 && n < 200) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk_bit(acc_cnt != a0, exp_acc, "accepted");
    chk_bit(rej_cnt != r0, !exp_acc, "rejected");
    chk_bit(busy_o, exp_acc, "busy");
    chk_bit(flag_ready_o, !exp_acc, "flag");
    n = 0;
    while (busy_o !== 1'b0 && n < 100) begin
      @(posedge ref_clk_i);
      n++;
    end
    settle();
    rd(b);
    chk_byte(b & 8'h03, 8'h00, "latch cleared");
  endtask

  task automatic t_reset();
    logic [7:0] b;
    rd(b);
    chk_byte(b, 8'h00, "reset status");
    host.send(FSB_OP_RD_FLAG, '0, '0);
    chk_byte(host.rsp_r, 8'h80, "flag byte");
    do_op(FSB_OP_PROGRAM, '0, 8'h00, 1'b0, 1'b0);
  endtask

  task automatic t_table();
    fsb_case_t c[12] = '{'{0, 4, 12'hff8, 0}, '{0, 4, 12'hff7, 1}, '{0, 3, 12'hfff, 1},
      '{0, 12, 12'h800, 0}, '{0, 12, 12'h7ff, 1}, '{1, 1, 12'h000, 0}, '{1, 1, 12'h001, 1},
      '{1, 12, 12'h7ff, 0}, '{1, 12, 12'h800, 1}, '{0, 13, 12'h000, 0}, '{1, 15, 12'hfff, 0},
      '{1, 0, 12'hfff, 1}};
    fsb_op_t ops[4] = '{FSB_OP_ERASE_SECTOR, FSB_OP_ERASE_4K, FSB_OP_PROGRAM, FSB_OP_ERASE_32K};
    logic [7:0] b;
    foreach (c[i]) begin
      do_op(FSB_OP_WR_STATUS, '0, sb(c[i].code, c[i].tb, 1'b0), 1'b1, 1'b1);
      rd(b);
      chk_byte(b, sb(c[i].code, c[i].tb, 1'b0), "status readback");
      do_op(ops[i % 4], {c[i].sec, 16'h0000}, 8'h5a, 1'b1, c[i].acc);
    end
  endtask

  task automatic t_die();
    do_op(FSB_OP_WR_STATUS, '0, sb(4'h1, 1'b0, 1'b0), 1'b1, 1'b1);
    do_op(FSB_OP_ERASE_DIE, '0, '0, 1'b1, 1'b0);
    do_op(FSB_OP_WR_STATUS, '0, sb(4'h0, 1'b0, 1'b0), 1'b1, 1'b1);
    do_op(FSB_OP_ERASE_DIE, '0, '0, 1'b1, 1'b1);
  endtask

  task automatic t_lock();
    logic [7:0] b;
    do_op(FSB_OP_WR_STATUS, '0, sb(4'h2, 1'b0, 1'b1), 1'b1, 1'b1);
    @(posedge ref_clk_i);
    wp_n_i <= 1'b0;
    do_op(FSB_OP_WR_STATUS, '0, 8'h00, 1'b1, 1'b0);
    host.send(FSB_OP_WR_ENABLE, '0, '0);
    settle();
    rd(b);
    chk_byte(b & 8'h02, 8'h02, "latch set");
    host.send(FSB_OP_WR_DISABLE, '0, '0);
    settle();
    rd(b);
    chk_byte(b & 8'h02, 8'h00, "latch off");
    do_op(FSB_OP_WR_STATUS, '0, 8'h00, 1'b1, 1'b0);
    rd(b);
    chk_byte(b, sb(4'h2, 1'b0, 1'b1), "locked status");
    @(posedge ref_clk_i);
    wp_n_i <= 1'b1;
    do_op(FSB_OP_WR_STATUS, '0, 8'h00, 1'b1, 1'b1);
    rd(b);
    chk_byte(b, 8'h00, "unlocked status");
  endtask

  task automatic summarize();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    failures = 0;
    checked = 0;
    acc_cnt = 0;
    rej_cnt = 0;
    bw = 0;
    reset_i = 1'b1;
    wp_n_i = 1'b1;
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge link_clk_i);
    t_reset();
    t_table();
    t_die();
    t_lock();
    summarize();
  end

  // Watchdog well beyond the expected run
  initial begin
    #1000000;
    failures++;
    summarize();
  end
endmodule
